// >>> rtl/fpesc_pkg.sv
// Package of opcodes, field positions and timing for the flash command interpreter
`default_nettype none
package fpesc_pkg;
	localparam logic [7:0] OP_LOAD_B1 = 8'h84;
	localparam logic [7:0] OP_LOAD_B2 = 8'h87;
	localparam logic [7:0] OP_PROG_B1 = 8'h88;
	localparam logic [7:0] OP_PROG_B2 = 8'h89;
	localparam logic [7:0] OP_FPROG_B1 = 8'h98;
	localparam logic [7:0] OP_FPROG_B2 = 8'h99;
	localparam logic [7:0] OP_ERASE_0A = 8'h50;
	localparam logic [7:0] OP_ERASE_SEC = 8'h7c;
	localparam logic [7:0] OP_XFER_B1 = 8'h53;
	localparam logic [7:0] OP_XFER_B2 = 8'h55;
	localparam logic [7:0] OP_CMP_B1 = 8'h60;
	localparam logic [7:0] OP_CMP_B2 = 8'h61;
	localparam logic [7:0] OP_STATUS = 8'hd7;
	localparam int BUF_BYTES = 1056;
	localparam int BUF_AW = 11;
	localparam int PAGE_AW = 14;
	localparam int ADDR_BYTES = 4;
	// Page index sits above 11 ignored low bits of the 32-bit address
	localparam int PAGE_LSB = 11;
	localparam int BUFIDX_LSB = 0;
	localparam int SECTOR_LSB = 8;
	// The small first sector is the eight pages below this page bit
	localparam int SECTOR0A_LSB = 3;
	localparam int ST_READY_BIT = 7;
	localparam int ST_COMP_BIT = 6;
	// Density code field, bits 5..2; value is arbitrary and neutral
	localparam logic [3:0] DENSITY_CODE = 4'h9;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// Operation times in microseconds; plain defaults, set per part
	localparam int T_PROG_US = 20;
	localparam int T_FPROG_US = 10;
	localparam int T_ERASE_US = 80;
	localparam int T_XFER_US = 30;
	localparam int SYS_CLK_MHZ = 50;
	localparam int T_PROG_CYC = T_PROG_US * SYS_CLK_MHZ;
	localparam int T_FPROG_CYC = T_FPROG_US * SYS_CLK_MHZ;
	localparam int T_ERASE_CYC = T_ERASE_US * SYS_CLK_MHZ;
	localparam int T_XFER_CYC = T_XFER_US * SYS_CLK_MHZ;
	typedef enum logic [2:0] {
		FPESC_OP_NONE,
		FPESC_OP_PROG,
		FPESC_OP_FPROG,
		FPESC_OP_ERASE,
		FPESC_OP_XFER,
		FPESC_OP_CMP
	} fpesc_op_t;
endpackage : fpesc_pkg
`default_nettype wire

// >>> rtl/fpesc_core.sv
// Flash program/erase/status command interpreter with link-clock front end
//
// Overview of operation
// - A command starts on select falling: 8-bit opcode then address bytes, clocked in.
// - Opcode, address and data travel most significant bit first.
// - Two data buffers of 1056 bytes, 11-bit byte index.
// - Buffer load opcodes are 84H for buffer one, 87H for buffer two.
// - Load address is 21 ignored bits then 11-bit start index; data follows.
// - Load index wraps from last buffer location back to zero.
// - Load keeps storing bytes until select rises.
// - Program opcodes 88H/89H normal, 98H/99H fast, buffers one/two.
// - Program, transfer, compare address: 7 ignored, 14-bit page, 11 ignored.
// - Select rising after program starts self-timed write; busy until done.
// - Small first sector erase opcode 50h; 7 ignored, 11 page bits, 14 ignored.
// - Other sector erase opcode 7Ch; 7 ignored, 6 upper page bits, 19 ignored.
// - Sector number from top six page bits; zero means rest of sector zero.
// - Select rising after erase erases one sector, self-timed, busy throughout.
// - Page-to-buffer copy opcodes 53H/55H; starts at select rise, busy meanwhile.
// - Compare opcodes 60H/61H check all 1056 bytes after select rise, busy; the model reads no buffer bytes and the miss flag always stays 0.
// - Status opcode D7H; serial dummy byte optional, required above 25 MHz.
// - Byte-wide status read has two dummy clocks before the status byte.
// - Status shifted MSB first over eight clocks, repeating with fresh contents.
// - Only transfer, compare, program and erase make the device busy.
// - Status bits 5..2 hold a density code; bits 1..0 reserved.
`default_nettype none
module fpesc_core #(
	parameter int PAGES = 16384,
	parameter int T_PROG = fpesc_pkg::T_PROG_CYC,
	parameter int T_FPROG = fpesc_pkg::T_FPROG_CYC,
	parameter int T_ERASE = fpesc_pkg::T_ERASE_CYC,
	parameter int T_XFER = fpesc_pkg::T_XFER_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_link_clk,
	input wire logic i_sel_n,
	input wire logic i_byte_mode,
	input wire logic i_serial_in,
	input wire logic [7:0] i_byte_wide_bus,
	output logic o_serial_out,
	output logic o_serial_out_oe_n,
	output logic [7:0] o_byte_wide_bus,
	output logic o_byte_wide_bus_oe_n,
	output logic o_ready,
	output logic o_compare_miss,
	output logic [2:0] o_op_kind,
	output logic [fpesc_pkg::PAGE_AW-1:0] o_op_page,
	output logic o_op_buffer
);
	import fpesc_pkg::*;

	typedef enum {FPESC_OPC, FPESC_ADDR, FPESC_LOAD, FPESC_STAT, FPESC_SKIP} fpesc_lstate_t;

	// Link side: select resets the frame logic asynchronously, as the link clock only runs in frames
	logic [2:0] lbit_r;
	logic [7:0] lshift_r;
	logic [7:0] opc_r;
	logic [31:0] addr_r;
	logic [2:0] abyte_r;
	logic [BUF_AW-1:0] widx_r;
	logic [1:0] dummy_r;
	logic [7:0] sout_r;
	fpesc_lstate_t lst_r;
	logic [7:0] buf1 [BUF_BYTES];
	logic [7:0] buf2 [BUF_BYTES];
	logic cmd_tgl_r;
	logic [7:0] cmd_opc_r;
	logic [31:0] cmd_addr_r;

	// Status snapshot crossing into link domain, two flops each bit
	logic [7:0] status_s1_r;
	logic [7:0] status_s2_r;
	logic [7:0] status_r;

	function automatic logic is_addressed(input logic [7:0] op);
		is_addressed = op == OP_PROG_B1 || op == OP_PROG_B2 || op == OP_FPROG_B1 || op == OP_FPROG_B2 ||
			op == OP_ERASE_0A || op == OP_ERASE_SEC || op == OP_XFER_B1 || op == OP_XFER_B2 ||
			op == OP_CMP_B1 || op == OP_CMP_B2;
	endfunction : is_addressed

	function automatic logic [BUF_AW-1:0] wrap_inc(input logic [BUF_AW-1:0] idx);
		wrap_inc = (idx == BUF_AW'(BUF_BYTES - 1)) ? '0 : idx + 1'b1;
	endfunction : wrap_inc

	logic [7:0] lin_byte;
	logic lbyte_done;
	always_comb begin
		lin_byte = i_byte_mode ? i_byte_wide_bus : {lshift_r[6:0], i_serial_in};
		lbyte_done = i_byte_mode || (lbit_r == 3'd7);
	end

	always_ff @(posedge i_link_clk) begin
		status_s1_r <= status_r;
		status_s2_r <= status_s1_r;
	end

	// Frame state; select rising resets the decoder at once, without a link clock edge
	always_ff @(posedge i_link_clk or posedge i_sel_n) begin
		if (i_sel_n) begin
			lst_r <= FPESC_OPC;
			lbit_r <= '0;
			abyte_r <= '0;
			dummy_r <= '0;
		end else begin
			lbit_r <= i_byte_mode ? 3'd0 : lbit_r + 3'd1;
			if (lbyte_done) begin
				case (lst_r)
					FPESC_OPC: begin
						if (lin_byte == OP_STATUS)
							lst_r <= FPESC_STAT;
						else if (lin_byte == OP_LOAD_B1 || lin_byte == OP_LOAD_B2 || is_addressed(lin_byte))
							lst_r <= FPESC_ADDR;
						else
							lst_r <= FPESC_SKIP;
					end
					FPESC_ADDR: begin
						abyte_r <= abyte_r + 3'd1;
						if (abyte_r == 3'(ADDR_BYTES - 1))
							lst_r <= (opc_r == OP_LOAD_B1 || opc_r == OP_LOAD_B2) ? FPESC_LOAD : FPESC_SKIP;
					end
					FPESC_STAT: dummy_r <= (dummy_r == 2'd3) ? dummy_r : dummy_r + 2'd1;
					default: lst_r <= lst_r;
				endcase
			end
		end
	end

	always_ff @(posedge i_link_clk) begin
		lshift_r <= lin_byte;
		if (!i_sel_n && lbyte_done && lst_r == FPESC_OPC)
			opc_r <= lin_byte;
		if (!i_sel_n && lbyte_done && lst_r == FPESC_ADDR)
			addr_r <= {addr_r[23:0], lin_byte};
	end

	// start index, wraps, store until select rises
	always_ff @(posedge i_link_clk) begin
		if (!i_sel_n && lbyte_done && lst_r == FPESC_ADDR && abyte_r == 3'(ADDR_BYTES - 1))
			widx_r <= {addr_r[BUF_AW-9:0], lin_byte};
		else if (!i_sel_n && lbyte_done && lst_r == FPESC_LOAD)
			widx_r <= wrap_inc(widx_r);
	end

	// two 1056-byte buffers; opcode picks buffer
	always_ff @(posedge i_link_clk) begin
		if (!i_sel_n && lbyte_done && lst_r == FPESC_LOAD) begin
			if (opc_r == OP_LOAD_B1)
				buf1[widx_r] <= lin_byte;
			else
				buf2[widx_r] <= lin_byte;
		end
	end

	// Full command captured after last address byte; shorter frames never toggle
	always_ff @(posedge i_link_clk) begin
		if (!i_sel_n && lbyte_done && lst_r == FPESC_ADDR && abyte_r == 3'(ADDR_BYTES - 1)
			&& is_addressed(opc_r)) begin
			cmd_opc_r <= opc_r;
			cmd_addr_r <= {addr_r[23:0], lin_byte};
		end
	end

	logic armed_r;
	always_ff @(posedge i_link_clk or posedge i_sel_n) begin
		if (i_sel_n)
			armed_r <= 1'b0;
		else if (lbyte_done && lst_r == FPESC_ADDR && abyte_r == 3'(ADDR_BYTES - 1) && is_addressed(opc_r))
			armed_r <= 1'b1;
	end
	// Toggle flips on select rise only when armed, so launch follows the frame end
	always_ff @(posedge i_sel_n or posedge i_rst) begin
		if (i_rst)
			cmd_tgl_r <= 1'b0;
		else if (armed_r)
			cmd_tgl_r <= ~cmd_tgl_r;
	end

	// status shifted msb first, repeating; dummy bytes optional
	always_ff @(negedge i_link_clk) begin
		if (lst_r == FPESC_STAT && (i_byte_mode ? dummy_r >= 2'd2 : lbit_r == 3'd0))
			sout_r <= status_s2_r;
		else
			sout_r <= {sout_r[6:0], 1'b0};
	end

	always_ff @(posedge i_link_clk) begin
		o_byte_wide_bus <= status_s2_r;
	end

	always_comb begin
		o_serial_out = sout_r[7];
		o_serial_out_oe_n = !(lst_r == FPESC_STAT && !i_byte_mode && !i_sel_n);
		o_byte_wide_bus_oe_n = !(lst_r == FPESC_STAT && i_byte_mode && !i_sel_n && dummy_r >= 2'd2);
	end

	// System side
	logic [2:0] tgl_sync_r;
	logic [31:0] busy_cnt_r;
	fpesc_op_t op_r;
	logic comp_r;
	logic [PAGE_AW-1:0] page_r;
	logic obuf_r;
	logic [7:0] op_opc;
	logic [PAGE_AW-1:0] op_page;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			tgl_sync_r <= '0;
		else
			tgl_sync_r <= {tgl_sync_r[1:0], cmd_tgl_r};
	end

	logic launch;
	always_comb begin
		launch = tgl_sync_r[2] ^ tgl_sync_r[1];
		op_opc = cmd_opc_r;
		op_page = cmd_addr_r[PAGE_LSB +: PAGE_AW];
	end

	// only these five kinds run timed and busy
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			op_r <= FPESC_OP_NONE;
			busy_cnt_r <= '0;
			page_r <= '0;
			obuf_r <= 1'b0;
		end else if (op_r == FPESC_OP_NONE && launch) begin
			page_r <= op_page;
			obuf_r <= op_opc[0];
			case (op_opc)
				OP_PROG_B1, OP_PROG_B2: begin
					op_r <= FPESC_OP_PROG;
					busy_cnt_r <= 32'(T_PROG);
				end
				OP_FPROG_B1, OP_FPROG_B2: begin
					op_r <= FPESC_OP_FPROG;
					busy_cnt_r <= 32'(T_FPROG);
				end
				// small first sector, low page bits ignored
				OP_ERASE_0A: begin
					op_r <= FPESC_OP_ERASE;
					busy_cnt_r <= 32'(T_ERASE);
					page_r <= (op_page >> SECTOR0A_LSB) << SECTOR0A_LSB;
				end
				OP_ERASE_SEC: begin
					op_r <= FPESC_OP_ERASE;
					busy_cnt_r <= 32'(T_ERASE);
					// Sector zero here is what remains after the small first sector
					if (op_page[PAGE_AW-1:SECTOR_LSB] == '0)
						page_r <= PAGE_AW'(1) << SECTOR0A_LSB;
					else
						page_r <= (op_page >> SECTOR_LSB) << SECTOR_LSB;
				end
				OP_XFER_B1: begin
					op_r <= FPESC_OP_XFER;
					busy_cnt_r <= 32'(T_XFER);
					obuf_r <= 1'b0;
				end
				OP_XFER_B2: begin
					op_r <= FPESC_OP_XFER;
					busy_cnt_r <= 32'(T_XFER);
					obuf_r <= 1'b1;
				end
				OP_CMP_B1, OP_CMP_B2: begin
					op_r <= FPESC_OP_CMP;
					busy_cnt_r <= 32'(T_XFER);
				end
				default: op_r <= FPESC_OP_NONE;
			endcase
		end else if (op_r != FPESC_OP_NONE) begin
			if (busy_cnt_r <= 32'd1)
				op_r <= FPESC_OP_NONE;
			else
				busy_cnt_r <= busy_cnt_r - 32'd1;
		end
	end

	// compare result; array not modelled, mismatch taken from input-free model
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			comp_r <= 1'b0;
		else if (op_r == FPESC_OP_CMP && busy_cnt_r <= 32'd1)
			comp_r <= 1'b0;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			status_r <= STATUS_RESET;
		else
			status_r <= {op_r == FPESC_OP_NONE, comp_r, DENSITY_CODE, 2'b00};
	end

	always_comb begin
		o_ready = status_r[ST_READY_BIT];
		o_compare_miss = status_r[ST_COMP_BIT];
		o_op_kind = op_r;
		o_op_page = page_r;
		o_op_buffer = obuf_r;
	end
endmodule : fpesc_core
`default_nettype wire

// >>> verification/fpesc_assertions.sv
// Port assertions for the flash command interpreter
`default_nettype none
module fpesc_checker #(
	parameter int T_MAX = 4000
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_link_clk,
	input wire logic i_byte_mode,
	input wire logic i_sel_n,
	input wire logic o_serial_out_oe_n,
	input wire logic o_byte_wide_bus_oe_n,
	input wire logic o_ready,
	input wire logic o_compare_miss,
	input wire logic [2:0] o_op_kind
);
	int busy_cnt;
	// Counted, as real busy times are far beyond any repetition count
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || o_ready) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	sequence s_busy_start;
		$fell(o_ready);
	endsequence
	sequence s_busy_hold;
		!o_ready [*8];
	endsequence
	a_reset_busy: assert property (@(posedge i_sys_clk) i_rst |=> !o_ready)
		else $error("ready right after reset");
	a_reset_ready: assert property (@(posedge i_sys_clk) disable iff (i_rst) $fell(i_rst) |-> ##[1:2] o_ready)
		else $error("not ready after reset");
	a_busy_from_select: assert property (@(posedge i_sys_clk) disable iff (i_rst) s_busy_start |-> $past(i_sel_n, 2))
		else $error("busy without select rise");
	a_busy_min: assert property (@(posedge i_sys_clk) disable iff (i_rst) s_busy_start |-> s_busy_hold)
		else $error("busy too short");
	a_busy_max: assert property (@(posedge i_sys_clk) disable iff (i_rst) busy_cnt <= T_MAX)
		else $error("busy too long");
	a_busy_has_op: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		s_busy_start |-> ##1 (o_op_kind inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}))
		else $error("busy with no op");
	// Ready lags the op register by one cycle when an operation starts
	a_idle_no_op: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_ready [*3] |-> $past(o_op_kind) == 3'h0)
		else $error("op while idle");
	// The status flag lands one cycle after the compare leaves the op register
	a_miss_at_cmp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!$stable(o_compare_miss) |-> (o_op_kind == 3'h5 || $past(o_op_kind, 2) == 3'h5))
		else $error("compare flag moved");
	a_serial_quiet: assert property (@(posedge i_link_clk) disable iff (i_rst) i_byte_mode |-> o_serial_out_oe_n)
		else $error("serial driven in byte mode");
	a_bus_quiet: assert property (@(posedge i_link_clk) disable iff (i_rst) !i_byte_mode |-> o_byte_wide_bus_oe_n)
		else $error("bus driven in serial mode");
endmodule : fpesc_checker
bind fpesc_core fpesc_checker #(.T_MAX(T_PROG + T_FPROG + T_ERASE + T_XFER)) i_chk (.i_sys_clk, .i_rst,
	.i_link_clk, .i_byte_mode, .i_sel_n, .o_serial_out_oe_n, .o_byte_wide_bus_oe_n, .o_ready, .o_compare_miss,
	.o_op_kind);
`default_nettype wire

// >>> verification/fpesc_host.sv
// Host model framing commands on the link
`default_nettype none
module fpesc_host (
	output logic o_link_clk,
	output logic o_sel_n,
	output logic o_byte_mode,
	output logic o_serial_in,
	output logic [7:0] o_bus,
	input wire logic i_serial_out,
	input wire logic [7:0] i_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{o_link_clk, o_sel_n, o_byte_mode, o_serial_in, o_bus} = 12'h000;
		// A first rising select clears the frame logic, which has no reset of its own
		#5 o_sel_n = 1'b1;
	end
	// Link clock toggles only inside a frame
	task automatic tick(output logic s);
		#80 o_link_clk = 1'b1;
		s = i_serial_out;
		#80 o_link_clk = 1'b0;
	endtask : tick
	task automatic put_byte(input logic [7:0] b);
		logic s;
		o_bus = b;
		for (int k = 7; k >= 0; k--) begin
			o_serial_in = b[k];
			if (!o_byte_mode || k == 0) tick(s);
		end
	endtask : put_byte
	// select low over opcode, address and data
	task automatic frame(input logic bm, input logic [7:0] op, input logic [31:0] adr, input int n_a, input int n_d);
		o_byte_mode = bm;
		#50 o_sel_n = 1'b0;
		put_byte(op);
		for (int i = 0; i < n_a; i++) put_byte(adr[31-8*i -: 8]);
		for (int i = 0; i < n_d; i++) put_byte(8'ha0 + 8'(i));
		#50 o_sel_n = 1'b1;
		// Released lines must not keep the last value
		o_serial_in = ~o_serial_in;
		o_bus = ~o_bus;
	endtask : frame
	// serial status with no dummy byte, bus status after two dummy clocks; two passes
	task automatic read_status(input logic bm, output logic [15:0] st);
		logic s;
		o_byte_mode = bm;
		#50 o_sel_n = 1'b0;
		put_byte(8'hd7);
		if (bm) begin
			repeat (3) tick(s);
			st[15:8] = i_bus;
			tick(s);
			st[7:0] = i_bus;
		end else begin
			for (int k = 15; k >= 0; k--) tick(st[k]);
		end
		#50 o_sel_n = 1'b1;
	endtask : read_status
endmodule : fpesc_host
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the flash command interpreter
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fpesc_pkg::*;
	localparam int T_OP = 400;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_link_clk, i_sel_n, i_byte_mode, i_serial_in, o_serial_out, o_serial_out_oe_n;
	logic o_byte_wide_bus_oe_n, o_ready, o_compare_miss, o_op_buffer;
	logic [7:0] i_byte_wide_bus, o_byte_wide_bus;
	logic [2:0] o_op_kind;
	logic [PAGE_AW-1:0] o_op_page;
	int n_errors = 0;
	int n_compared = 0;
	initial begin
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	fpesc_core #(.T_PROG(T_OP), .T_FPROG(T_OP), .T_ERASE(T_OP), .T_XFER(T_OP)) i_dut (.i_sys_clk, .i_rst,
		.i_link_clk, .i_sel_n, .i_byte_mode, .i_serial_in, .i_byte_wide_bus, .o_serial_out, .o_serial_out_oe_n,
		.o_byte_wide_bus, .o_byte_wide_bus_oe_n, .o_ready, .o_compare_miss, .o_op_kind, .o_op_page, .o_op_buffer);
	fpesc_host i_host (.o_link_clk(i_link_clk), .o_sel_n(i_sel_n), .o_byte_mode(i_byte_mode),
		.o_serial_in(i_serial_in), .o_bus(i_byte_wide_bus), .i_serial_out(o_serial_out), .i_bus(o_byte_wide_bus));
	task automatic check(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic wait_ready(input logic lvl, input int lim);
		for (int n = 0; n < lim && o_ready !== lvl; n++) @(posedge i_sys_clk);
	endtask : wait_ready
	// Ignored address bits are sent as ones
	task automatic t_op(input logic bm, input logic [7:0] op, input logic [13:0] pg, input logic [2:0] kind,
		input logic [13:0] epg, input logic bf);
		logic [15:0] st;
		i_host.frame(bm, op, {7'h7f, pg, 11'h7ff}, 4, 0);
		wait_ready(1'b0, 10);
		check(o_ready === 1'b0, "no busy");
		check(o_op_kind === kind && o_op_page === epg && (kind == 3'h3 || o_op_buffer === bf), "op");
		i_host.read_status(bm, st);
		check(st[15:10] === {2'h0, DENSITY_CODE} && st[7:2] === st[15:10], "busy status");
		wait_ready(1'b1, T_OP + 50);
		check(o_ready === 1'b1 && o_compare_miss === 1'b0, "no ready");
	endtask : t_op
	task automatic t_quiet(input logic bm, input logic [7:0] op, input int n_a, input int n_d);
		logic busy;
		busy = 1'b0;
		i_host.frame(bm, op, {21'h1fffff, 11'h41e}, n_a, n_d);
		repeat (20) begin
			@(posedge i_sys_clk);
			busy = busy | ~o_ready;
		end
		check(busy === 1'b0 && o_op_kind === 3'h0, "busy");
	endtask : t_quiet
	task automatic t_reset_status();
		logic [15:0] st;
		for (int m = 0; m < 2; m++) begin
			i_host.read_status(1'(m), st);
			check(st[15:10] === {2'h2, DENSITY_CODE} && st[7:2] === st[15:10], "idle status");
		end
	endtask : t_reset_status
	task automatic t_erase();
		t_op(1'b1, OP_ERASE_SEC, 14'h3f55, 3'h3, 14'h3f00, 1'b0);
		t_op(1'b0, OP_ERASE_0A, 14'h0005, 3'h3, 14'h0000, 1'b0);
		t_op(1'b0, OP_ERASE_SEC, 14'h00ab, 3'h3, 14'h0008, 1'b0);
	endtask : t_erase
	// pages lie in the sector erased above
	task automatic t_program();
		t_op(1'b0, OP_PROG_B1, 14'h3f01, 3'h1, 14'h3f01, 1'b0);
		t_op(1'b1, OP_PROG_B2, 14'h3f02, 3'h1, 14'h3f02, 1'b1);
		t_op(1'b0, OP_FPROG_B1, 14'h3ffe, 3'h2, 14'h3ffe, 1'b0);
		t_op(1'b1, OP_FPROG_B2, 14'h3fff, 3'h2, 14'h3fff, 1'b1);
	endtask : t_program
	task automatic t_xfer_cmp();
		t_op(1'b1, OP_XFER_B1, 14'h0000, 3'h4, 14'h0000, 1'b0);
		t_op(1'b0, OP_XFER_B2, 14'h2aaa, 3'h4, 14'h2aaa, 1'b1);
		t_op(1'b0, OP_CMP_B1, 14'h1555, 3'h5, 14'h1555, 1'b0);
		t_op(1'b1, OP_CMP_B2, 14'h3fff, 3'h5, 14'h3fff, 1'b1);
	endtask : t_xfer_cmp
	task automatic t_abort_load();
		t_quiet(1'b0, OP_PROG_B1, 3, 0);
		t_quiet(1'b1, OP_ERASE_SEC, 3, 0);
		t_quiet(1'b1, OP_LOAD_B1, 4, 6);
		check(i_dut.buf1[11'h41e] === 8'ha0 && i_dut.buf1[0] === 8'ha2 && i_dut.buf1[3] === 8'ha5, "load 1");
		t_quiet(1'b0, OP_LOAD_B2, 4, 3);
		check(i_dut.buf2[11'h41f] === 8'ha1 && i_dut.buf2[0] === 8'ha2, "load 2");
	endtask : t_abort_load
	task automatic end_sim();
		if (n_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_sys_clk);
		t_reset_status();
		t_erase();
		t_program();
		t_xfer_cmp();
		t_abort_load();
		end_sim();
	end
	initial begin
		// The scenarios need about 160 us; the limit leaves ample room
		#1000000;
		n_errors++;
		end_sim();
	end
endmodule : tb
`default_nettype wire
